// *** scb_pkg.sv ***
// Package: register map, field positions and timing for the clock and boot control block
package scb_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] ADDR_CLKSEL   = 4'h0;
   localparam logic [3:0] ADDR_XTALCTL  = 4'h1;
   localparam logic [3:0] ADDR_RCTRIM   = 4'h2;
   localparam logic [3:0] ADDR_STATUS   = 4'h3;
   localparam logic [3:0] ADDR_OPTION   = 4'h4;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int XTAL_EN_BIT  = 7;
   localparam int FAST_EN_BIT  = 4;
   localparam int SLOW_EN_BIT  = 2;
   // ----------------------------------------
   // Clock-select codes and reset values
   // ----------------------------------------
   localparam logic [7:0] CLKSEL_RESET  = 8'hf4;
   localparam logic [7:0] CLKSEL_DIV2   = 8'h34;
   localparam logic [7:0] CLKSEL_DIV4   = 8'h14;
   localparam logic [7:0] CLKSEL_DIV8   = 8'h3c;
   localparam logic [7:0] CLKSEL_DIV16  = 8'h1c;
   localparam logic [7:0] CLKSEL_DIV32  = 8'h7c;
   localparam logic [7:0] CLKSEL_SLOW   = 8'he4;
   localparam logic [7:0] CLKSEL_XTAL   = 8'hb0;
   localparam logic [7:0] XTALCTL_RESET = 8'h00;
   localparam logic [7:0] TRIM_RESET    = 8'h80;
   // ----------------------------------------
   // Boot delay in slow RC cycles
   // ----------------------------------------
   localparam int BOOT_FAST_CYC   = 45;
   localparam int BOOT_NORMAL_CYC = 3000;
   // Calibration option codes
   localparam logic [2:0] CAL_OFF = 3'h0;
   localparam logic [2:0] CAL_D2  = 3'h1;
   localparam logic [2:0] CAL_D4  = 3'h2;
   localparam logic [2:0] CAL_D8  = 3'h3;
   localparam logic [2:0] CAL_D16 = 3'h4;
   localparam logic [2:0] CAL_D32 = 3'h5;
   localparam logic [2:0] CAL_SLW = 3'h6;
   typedef enum logic [1:0] {ST_RESET, ST_BOOT, ST_RUN} scb_state_e;
   typedef enum logic [2:0] {SRC_SLOW, SRC_FAST, SRC_XTAL} scb_src_e;
endpackage : scb_pkg

// *** scb_clock_boot.sv ***
// Clock source selection, divider and power-up boot sequencing
`timescale 1ns/1ps
//
// Contract
// - Separate enables: crystal control bit 7, clock-select bits 4 and 2.
// - Software selects any oscillator through clock-select, with a divider for the fast RC only.
// - Power-on reset holds core reset until boot delay elapses.
// - Boot delay counts slow RC cycles: 45 fast, 3000 normal.
// - Fast and slow RC both run once boot completes, except after the 0xE4 option, which leaves fast RC off.
// - Fast RC trimmed from calibration register, target 16MHz.
// - Clock-select 0x34 gives fast RC divided by two.
// - Clock-select 0x14 gives fast RC divided by four.
// - Clock-select 0x3C gives fast RC divided by eight.
// - Clock-select 0x1C gives fast RC divided by sixteen.
// - Clock-select 0x7C gives fast RC divided by thirty-two.
// - Clock-select 0xE4 runs slow RC directly, fast RC disabled.
// - Calibrated boot: watchdog off, slow RC on, port A bit five input.
// - Uncalibrated boot: reset clock-select, untrimmed fast RC on, watchdog on.
// - Calibration accepts 14-18MHz targets and dividers 2..32.
// - Calibration is applied once, only when memory is programmed.
// - Clock-select write after boot switches immediately; RC enables follow the written value at once.
module scb_clock_boot
   import scb_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Oscillator ticks (one-cycle pulses at each rising edge of each oscillator)
   input  wire logic       slowTick,
   input  wire logic       fastTick,
   input  wire logic       xtalTick,
   // One-time option memory
   input  wire logic [2:0] calOption,
   input  wire logic [7:0] calTrim,
   input  wire logic       calProgrammed,
   input  wire logic       fastBoot,
   // Register port
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdata,
   // Oscillator controls and system clock
   output logic            xtalEn,
   output logic            fastEn,
   output logic            slowEn,
   output logic      [7:0] fastTrim,
   output logic            system_clock_choice,
   output logic            coreRst_n,
   output logic            wdtEn,
   output logic            portA5Input
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   scb_state_e  state_ff, nxt_state;
   logic [11:0] bootCnt_ff, nxt_bootCnt;
   logic [7:0]  clkSel_ff, nxt_clkSel;
   logic [7:0]  xtalCtl_ff, nxt_xtalCtl;
   logic [7:0]  trim_ff, nxt_trim;
   logic        wdt_ff, nxt_wdt;
   logic        calDone_ff, nxt_calDone;
   logic [7:0]  rdata_ff, nxt_rdata;
   logic [4:0]  divCnt_ff, nxt_divCnt;
   logic        system_clock_choice_ff, nxt_system_clock_choice;
   logic        coreRst_ff, nxt_coreRst;

   localparam logic [11:0] BOOT_FAST_LEN   = 12'(BOOT_FAST_CYC - 1);
   localparam logic [11:0] BOOT_NORMAL_LEN = 12'(BOOT_NORMAL_CYC - 1);

   // Decode of the selected source and divide ratio (ratio = 2^exp)
   function automatic scb_src_e srcOf(input logic [7:0] sel);
      if (sel == CLKSEL_RESET)
         srcOf = SRC_FAST;
      else if (sel[7:5] == 3'b111 && sel[3])
         srcOf = SRC_FAST;
      else if (sel[7:5] == 3'b111)
         srcOf = SRC_SLOW;
      else if (sel[7:5] == 3'b101)
         srcOf = SRC_XTAL;
      else
         srcOf = SRC_FAST;
   endfunction : srcOf

   function automatic logic [2:0] divExp(input logic [7:0] sel);
      unique case (sel)
         CLKSEL_DIV2:  divExp = 3'h1;
         CLKSEL_DIV4:  divExp = 3'h2;
         CLKSEL_DIV8:  divExp = 3'h3;
         CLKSEL_DIV16: divExp = 3'h4;
         CLKSEL_DIV32: divExp = 3'h5;
         CLKSEL_RESET: divExp = 3'h6;
         default:      divExp = 3'h0;
      endcase
   endfunction : divExp

   // ----------------------------------------
   // Boot sequencing and registers
   // ----------------------------------------
   always_comb
   begin
      nxt_state   = state_ff;
      nxt_bootCnt = bootCnt_ff;
      nxt_clkSel  = clkSel_ff;
      nxt_xtalCtl = xtalCtl_ff;
      nxt_trim    = trim_ff;
      nxt_wdt     = wdt_ff;
      nxt_calDone = calDone_ff;
      nxt_coreRst = coreRst_ff;
      nxt_rdata   = 8'h00;
      unique case (state_ff)
         ST_RESET:
         begin
            nxt_state   = ST_BOOT;
            nxt_bootCnt = fastBoot ? BOOT_FAST_LEN : BOOT_NORMAL_LEN;
         end
         ST_BOOT:
         begin
            nxt_coreRst = 1'b0;
            if (slowTick)
            begin
               if (bootCnt_ff == 12'h000)
               begin
                  nxt_state   = ST_RUN;
                  nxt_coreRst = 1'b1;
                  // Option applied only if programmed, and only once per power-up
                  if (calProgrammed && !calDone_ff && calOption != CAL_OFF)
                  begin
                     nxt_trim = calTrim;
                     nxt_wdt  = 1'b0;
                     unique case (calOption)
                        CAL_D2:  nxt_clkSel = CLKSEL_DIV2;
                        CAL_D4:  nxt_clkSel = CLKSEL_DIV4;
                        CAL_D8:  nxt_clkSel = CLKSEL_DIV8;
                        CAL_D16: nxt_clkSel = CLKSEL_DIV16;
                        CAL_D32: nxt_clkSel = CLKSEL_DIV32;
                        default: nxt_clkSel = CLKSEL_SLOW;
                     endcase
                  end
                  else
                  begin
                     nxt_wdt = 1'b1;
                  end
                  nxt_calDone = 1'b1;
               end
               else
               begin
                  nxt_bootCnt = bootCnt_ff - 12'h001;
               end
            end
         end
         ST_RUN:
         begin
            if (regWr)
            begin
               // New selection takes effect at once; old oscillator stays as written
               unique case (regAddr)
                  ADDR_CLKSEL:  nxt_clkSel  = regWdata;
                  ADDR_XTALCTL: nxt_xtalCtl = regWdata;
                  ADDR_RCTRIM:  nxt_trim    = regWdata;
                  default:      nxt_clkSel  = clkSel_ff;
               endcase
            end
         end
         default: nxt_state = ST_RESET;
      endcase
      if (regRd)
      begin
         unique case (regAddr)
            ADDR_CLKSEL:  nxt_rdata = clkSel_ff;
            ADDR_XTALCTL: nxt_rdata = xtalCtl_ff;
            ADDR_RCTRIM:  nxt_rdata = trim_ff;
            ADDR_STATUS:  nxt_rdata = {5'h00, wdt_ff, calDone_ff, coreRst_ff};
            ADDR_OPTION:  nxt_rdata = {4'h0, fastBoot, calOption};
            default:      nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff   <= ST_RESET;
         bootCnt_ff <= 12'h000;
         clkSel_ff  <= CLKSEL_RESET;
         xtalCtl_ff <= XTALCTL_RESET;
         trim_ff    <= TRIM_RESET;
         wdt_ff     <= 1'b1;
         calDone_ff <= 1'b0;
         coreRst_ff <= 1'b0;
         rdata_ff   <= 8'h00;
      end
      else
      begin
         state_ff   <= nxt_state;
         bootCnt_ff <= nxt_bootCnt;
         clkSel_ff  <= nxt_clkSel;
         xtalCtl_ff <= nxt_xtalCtl;
         trim_ff    <= nxt_trim;
         wdt_ff     <= nxt_wdt;
         calDone_ff <= nxt_calDone;
         coreRst_ff <= nxt_coreRst;
         rdata_ff   <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // System clock divider
   // ----------------------------------------
   logic     srcTick;
   scb_src_e curSrc;
   logic     phaseEnd;
   logic [4:0] halfLen;
   logic       ratioOne;

   always_comb
   begin
      curSrc  = srcOf(clkSel_ff);
      unique case (curSrc)
         SRC_FAST: srcTick = fastTick & clkSel_ff[FAST_EN_BIT];
         SRC_XTAL: srcTick = xtalTick & xtalCtl_ff[XTAL_EN_BIT];
         default:  srcTick = slowTick & clkSel_ff[SLOW_EN_BIT];
      endcase
      // Direct mode copies the source pulse, so its duty follows the tick width
      ratioOne = (divExp(clkSel_ff) == 3'h0);
      // Half-period in source ticks, less one
      halfLen  = ratioOne ? 5'h00 : 5'((7'h01 << (divExp(clkSel_ff) - 3'h1)) - 7'h01);
      phaseEnd = srcTick && !ratioOne && (divCnt_ff >= halfLen);
      // In divided modes the output only toggles at a phase end; the count carries over a switch, so a smaller divider can shorten a phase
      nxt_divCnt = (srcTick && !ratioOne) ? (phaseEnd ? 5'h00 : divCnt_ff + 5'h01) : divCnt_ff;
      nxt_system_clock_choice = ratioOne ? srcTick : (phaseEnd ? ~system_clock_choice_ff : system_clock_choice_ff);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divCnt_ff <= 5'h00;
         system_clock_choice_ff <= 1'b0;
      end
      else
      begin
         divCnt_ff <= nxt_divCnt;
         system_clock_choice_ff <= nxt_system_clock_choice;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign regRdata    = rdata_ff;
   assign xtalEn      = xtalCtl_ff[XTAL_EN_BIT];
   assign fastEn      = clkSel_ff[FAST_EN_BIT];
   assign slowEn      = clkSel_ff[SLOW_EN_BIT];
   assign fastTrim    = trim_ff;
   assign system_clock_choice      = system_clock_choice_ff;
   assign coreRst_n   = coreRst_ff;
   assign wdtEn       = wdt_ff;
   assign portA5Input = 1'b1;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_core_held_boot: assert property (@(posedge clk) disable iff (!rst_n)
      state_ff != ST_RUN |-> !coreRst_ff) else $error("Core released before boot end");
   a_boot_end_release: assert property (@(posedge clk) disable iff (!rst_n)
      state_ff == ST_BOOT && slowTick && bootCnt_ff == 12'h000 |=> coreRst_ff && state_ff == ST_RUN)
      else $error("Boot end did not release core");
   a_wdt_cal_off: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(coreRst_ff) && $past(calProgrammed) && $past(calOption) != CAL_OFF |-> !wdt_ff)
      else $error("Watchdog on after calibrated boot");
   a_wdt_uncal: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(coreRst_ff) && (!$past(calProgrammed) || $past(calOption) == CAL_OFF)
      |-> wdt_ff && clkSel_ff == CLKSEL_RESET)
      else $error("Uncalibrated boot state wrong");
   a_sel_write: assert property (@(posedge clk) disable iff (!rst_n)
      state_ff == ST_RUN && regWr && regAddr == ADDR_CLKSEL |=> clkSel_ff == $past(regWdata))
      else $error("Clock-select write not immediate");
   a_div2_phase: assert property (@(posedge clk) disable iff (!rst_n)
      clkSel_ff == CLKSEL_DIV2 && $stable(clkSel_ff) && fastTick |=> $changed(system_clock_choice_ff))
      else $error("Divide-by-two phase wrong");
   a_slow_enable: assert property (@(posedge clk) disable iff (!rst_n)
      clkSel_ff == CLKSEL_SLOW |-> slowEn && !fastEn ##1 system_clock_choice_ff == $past(slowTick))
      else $error("Slow select enables wrong");
   a_rd_latency: assert property (@(posedge clk) disable iff (!rst_n)
      regRd && regAddr == ADDR_CLKSEL |=> regRdata == $past(clkSel_ff))
      else $error("Read data wrong");
   c_fast_boot:  cover property (@(posedge clk) disable iff (!rst_n) fastBoot && $rose(coreRst_ff));
   c_cal_boot:   cover property (@(posedge clk) disable iff (!rst_n) $rose(coreRst_ff) && !wdt_ff);
   c_sel_switch: cover property (@(posedge clk) disable iff (!rst_n) regWr && regAddr == ADDR_CLKSEL);
endmodule : scb_clock_boot

// *** tb_scb_clock_boot.sv ***
// Self-checking testbench for the clock and boot control block
`timescale 1ns/1ps
module tb_top;
   import scb_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic       clk           = 1'b0;
   logic       rst_n         = 1'b0;
   logic       slowTick      = 1'b0;
   logic       fastTick      = 1'b0;
   logic       xtalTick      = 1'b0;
   logic [2:0] calOption     = 3'h0;
   logic [7:0] calTrim       = 8'h00;
   logic       calProgrammed = 1'b1;
   logic       fastBoot      = 1'b1;
   logic [3:0] regAddr       = 4'h0;
   logic [7:0] regWdata      = 8'h00;
   logic       regWr         = 1'b0;
   logic       regRd         = 1'b0;
   logic [7:0] regRdata;
   logic       xtalEn;
   logic       fastEn;
   logic       slowEn;
   logic [7:0] fastTrim;
   logic       system_clock_choice;
   logic       coreRst_n;
   logic       wdtEn;
   logic       portA5Input;
   logic       freeRun       = 1'b0;
   int         cyc           = 0;
   int         pend          = 0;
   int         failCount     = 0;
   int         compares      = 0;
   integer     seed          = 32'he99a4c88;

   scb_clock_boot u_scb_clock_boot (.clk(clk), .rst_n(rst_n), .slowTick(slowTick), .fastTick(fastTick),
      .xtalTick(xtalTick), .calOption(calOption), .calTrim(calTrim), .calProgrammed(calProgrammed),
      .fastBoot(fastBoot), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .xtalEn(xtalEn), .fastEn(fastEn), .slowEn(slowEn), .fastTrim(fastTrim),
      .system_clock_choice(system_clock_choice), .coreRst_n(coreRst_n), .wdtEn(wdtEn), .portA5Input(portA5Input));

   always #2 clk = ~clk;

   // ----------------------------------------
   // Oscillator ticks
   // ----------------------------------------
   // Fast RC period is two clocks, slow RC eight; during boot slow ticks are counted out by hand
   always @(posedge clk)
   begin
      cyc      <= cyc + 1;
      fastTick <= cyc[0];
      xtalTick <= (cyc[1:0] == 2'h0);
      slowTick <= freeRun ? (cyc[2:0] == 3'h0) : (pend != 0);
      if (!freeRun && pend != 0)
         pend <= pend - 1;
   end

   // ----------------------------------------
   // Expectations and checks
   // ----------------------------------------
   function automatic logic [7:0] expClk(input logic [2:0] opt);
      case (opt)
         3'h1:    return CLKSEL_DIV2;
         3'h2:    return CLKSEL_DIV4;
         3'h3:    return CLKSEL_DIV8;
         3'h4:    return CLKSEL_DIV16;
         3'h5:    return CLKSEL_DIV32;
         3'h6:    return CLKSEL_SLOW;
         default: return CLKSEL_RESET;
      endcase
   endfunction : expClk

   // System clock period in bench clocks for each option
   function automatic int expPer(input logic [2:0] opt);
      return (opt == 3'h6) ? 8 : ((opt == 3'h0 || opt == 3'h7) ? 128 : (2 << opt));
   endfunction : expPer

   task automatic summarize();
      $display("Comparisons %0d, errors %0d", compares, failCount);
      if (failCount == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp)
      begin
         failCount++;
         $display("Error %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp, input string msg);
      chk8({7'h00, got}, {7'h00, exp}, msg);
   endtask : chk1

   task automatic chkCnt(input int got, input int exp, input string msg);
      compares++;
      if (got != exp)
      begin
         failCount++;
         $display("Error %0t: %s got %0d expected %0d", $time, msg, got, exp);
      end
   endtask : chkCnt

   task automatic timeout(input string msg);
      failCount++;
      $display("Error %0t: timeout %s", $time, msg);
      summarize();
   endtask : timeout

   // ----------------------------------------
   // Register port and waits
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd

   task automatic waitRise(output int c);
      logic prev;
      c    = 0;
      prev = system_clock_choice;
      while (!(prev === 1'b0 && system_clock_choice === 1'b1))
      begin
         prev = system_clock_choice;
         @(posedge clk);
         #1 c++;
         if (c > 600)
            timeout("system clock");
      end
   endtask : waitRise

   // Second rise after settling gives a full period of the new setting
   task automatic period(input int exp);
      int c;
      waitRise(c);
      waitRise(c);
      waitRise(c);
      chkCnt(c, exp, "system clock period");
   endtask : period

   task automatic boot(input logic [2:0] opt, input logic fb);
      int n;
      int k;
      @(posedge clk);
      rst_n     <= 1'b0;
      calOption <= opt;
      fastBoot  <= fb;
      calTrim   <= 8'($random(seed));
      calProgrammed <= (opt != 3'h7);
      freeRun   <= 1'b0;
      repeat (20) @(posedge clk);
      #1 chk1(coreRst_n, 1'b0, "core reset during power-on");
      chk8(regRdata, 8'h00, "idle read data");
      @(posedge clk);
      rst_n <= 1'b1;
      n = fb ? BOOT_FAST_CYC : BOOT_NORMAL_CYC;
      wr(ADDR_CLKSEL, 8'h5a);
      @(negedge clk) pend = n - 1;
      for (k = 0; pend != 0; k++)
      begin
         @(posedge clk);
         if (k > 4000)
            timeout("boot ticks");
      end
      repeat (4) @(posedge clk);
      #1 chk1(coreRst_n, 1'b0, "core released one tick early");
      @(negedge clk) pend = 1;
      repeat (4) @(posedge clk);
      #1 chk1(coreRst_n, 1'b1, "core not released");
      freeRun = 1'b1;
   endtask : boot

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      logic [7:0] d;
      logic [7:0] c;
      logic [2:0] k;
      logic       uncal;
      // Each calibration option, option 3 with the long boot, 7 with the memory unprogrammed
      for (int o = 0; o < 8; o++)
      begin
         k = 3'(o);
         uncal = (k == 3'h0 || k == 3'h7);
         boot(k, k != 3'h3);
         c = expClk(k);
         rd(ADDR_CLKSEL, d);
         chk8(d, c, "clock select after boot");
         chk8(fastTrim, uncal ? TRIM_RESET : calTrim, "trim after boot");
         chk1(slowEn, 1'b1, "slow RC after boot");
         if (!uncal)
            chk1(fastEn, c[FAST_EN_BIT], "fast RC after boot");
         chk1(wdtEn, uncal, "watchdog after boot");
         chk1(portA5Input, 1'b1, "port pin mode");
         period(expPer(k));
      end
      // Random divider switches, fast RC kept on across each
      repeat (6)
      begin
         k = 3'(1 + ($unsigned($random(seed)) % 5));
         wr(ADDR_CLKSEL, expClk(k));
         chk1(fastEn, 1'b1, "fast RC enable");
         rd(ADDR_CLKSEL, d);
         chk8(d, expClk(k), "clock select readback");
         period(expPer(k));
      end
      c = 8'($random(seed));
      wr(ADDR_RCTRIM, c);
      chk8(fastTrim, c, "trim write");
      wr(ADDR_XTALCTL, 8'h80);
      chk1(xtalEn, 1'b1, "crystal enable");
      rd(ADDR_XTALCTL, d);
      chk8(d, 8'h80, "crystal control readback");
      wr(ADDR_CLKSEL, CLKSEL_DIV2 & 8'hfb);
      chk1(slowEn, 1'b0, "slow RC disable");
      chk1(fastEn, 1'b1, "fast RC kept");
      wr(ADDR_XTALCTL, 8'h00);
      chk1(xtalEn, 1'b0, "crystal disable");
      rd(4'hf, d);
      chk8(d, 8'h00, "unmapped read");
      summarize();
   end
endmodule : tb_top
